// ===== smbus_tgt_defines.svh
// Timing counts and field constants for the serial target port
`ifndef SMBUS_TGT_DEFINES_SVH
`define SMBUS_TGT_DEFINES_SVH
`define CLK_HZ 20000000
`define TIMEOUT_MIN_MS 25
`define TIMEOUT_MAX_MS 35
// Aim between the two limits: 30 ms
`define TIMEOUT_MS 30
`define TIMEOUT_CYC ((`TIMEOUT_MS * (`CLK_HZ / 1000)))
`define POR_READY_MS 5
`define POR_READY_CYC ((`POR_READY_MS * (`CLK_HZ / 1000)))
`define CLOCK_HIGH_MAX_US 50
`define ADDR_BASE 7'h68
`define ADDR_MID 7'h6A
`define ADDR_HIGH 7'h6C
`endif

// ===== smbus_tgt_pkg.sv
// Types shared by the serial target port
package smbus_tgt_pkg;
  typedef enum logic [1:0] {
    SEL_LOW = 2'b00,
    SEL_MID = 2'b01,
    SEL_HIGH = 2'b10
  } addr_sel_e;
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } bus_ev_s;
  typedef struct packed {
    logic [7:0] data;
    logic is_read;
  } xfer_s;
endpackage

// ===== smbus_low_timer.sv
// Counts one uninterrupted low interval of a bus line
`timescale 1ns/100ps
`default_nettype none
module smbus_low_timer #(
  parameter int unsigned LIMIT = 600000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic line_i,
  output logic expired_o
);
  logic [19:0] cnt_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 20'h0_0000;
    end else if (line_i) begin
      cnt_reg <= 20'h0_0000;
    end else if (cnt_reg != LIMIT[19:0]) begin
      cnt_reg <= cnt_reg + 20'h0_0001;
    end
  end
  // Pulse once per low interval, not a level, so the abort is single
  assign expired_o = !line_i && (cnt_reg == LIMIT[19:0] - 20'h0_0001);
endmodule
`default_nettype wire

// ===== smbus_target.sv
// Serial target port with clock-low and data-low bus timeouts
`timescale 1ns/100ps
`default_nettype none
`include "smbus_tgt_defines.svh"
module smbus_target (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Control pins
  input wire logic SUPPLY_GOOD_INPUT_I,
  input wire smbus_tgt_pkg::addr_sel_e TARGET_ADDRESS_SELECT_I,
  // Bus pins
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  // User side
  output var smbus_tgt_pkg::xfer_s XFER_O,
  output logic XFER_VALID_O,
  input wire logic [7:0] RD_DATA_I,
  output logic READY_O,
  output logic TIMEOUT_O
);
  import smbus_tgt_pkg::*;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_WR = 3'b011,
    ST_RD = 3'b100,
    ST_RACK = 3'b101,
    ST_SKIP = 3'b110
  } state_e;
  localparam int unsigned TO_CYC = `TIMEOUT_CYC;
  localparam logic [19:0] POR_CYC = 20'(`POR_READY_CYC);
  logic [2:0] scl_sync_reg, sda_sync_reg;
  logic [1:0] pg_sync_reg;
  logic [1:0] sel_meta_reg;
  addr_sel_e sel_sync_reg;
  logic scl, sda, pg_ok;
  bus_ev_s ev;
  logic scl_to, sda_to, abort;
  logic [19:0] por_reg;
  logic ready_reg;
  logic [6:0] my_addr_reg;
  state_e state_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic rd_reg;
  logic sda_oe_reg;
  xfer_s xfer_reg;
  logic xvalid_reg;
  logic to_reg;

  // Two-stage synchronisers; stage 0 read only by stage 1
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scl_sync_reg <= 3'b111;
      sda_sync_reg <= 3'b111;
      pg_sync_reg <= 2'b00;
      sel_meta_reg <= 2'b00;
      sel_sync_reg <= SEL_LOW;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], SCL_I};
      sda_sync_reg <= {sda_sync_reg[1:0], SDA_I};
      pg_sync_reg <= {pg_sync_reg[0], SUPPLY_GOOD_INPUT_I};
      // Strap pin is asynchronous too, so it gets the same two stages
      sel_meta_reg <= TARGET_ADDRESS_SELECT_I;
      sel_sync_reg <= addr_sel_e'(sel_meta_reg);
    end
  end
  assign scl = scl_sync_reg[1];
  assign sda = sda_sync_reg[1];
  assign pg_ok = pg_sync_reg[1];
  // One driver for the whole event bundle
  assign ev = '{
    start: scl && scl_sync_reg[2] && sda_sync_reg[2] && !sda,
    stop: scl && scl_sync_reg[2] && !sda_sync_reg[2] && sda,
    rise: scl && !scl_sync_reg[2],
    fall: !scl && scl_sync_reg[2]
  };

  smbus_low_timer #(.LIMIT(TO_CYC)) u_scl_timer (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .line_i(scl),
    .expired_o(scl_to)
  );
  smbus_low_timer #(.LIMIT(TO_CYC)) u_sda_timer (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .line_i(sda),
    .expired_o(sda_to)
  );
  assign abort = scl_to || sda_to;

  // Readiness delay after reset, exactly the 5 ms bound (POR_CYC cycles)
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      por_reg <= 20'h0_0000;
      ready_reg <= 1'b0;
    end else if (!ready_reg) begin
      por_reg <= por_reg + 20'h0_0001;
      ready_reg <= (por_reg == POR_CYC - 20'h0_0001);
    end
  end

  // Strap captured by a clocked process while not yet ready
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      my_addr_reg <= `ADDR_BASE;
    end else if (!ready_reg) begin
      case (sel_sync_reg)
        SEL_LOW: my_addr_reg <= `ADDR_BASE;
        SEL_MID: my_addr_reg <= `ADDR_MID;
        SEL_HIGH: my_addr_reg <= `ADDR_HIGH;
        default: my_addr_reg <= `ADDR_BASE;
      endcase
    end
  end

  // Protocol state machine
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      rd_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (!ready_reg || !pg_ok || abort) begin
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
      bit_reg <= 4'h0;
    end else if (ev.start) begin
      state_reg <= ST_ADDR;
      bit_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (ev.stop) begin
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_WR: begin
          if (ev.rise) begin
            sh_reg <= {sh_reg[6:0], sda};
            bit_reg <= bit_reg + 4'h1;
          end else if (ev.fall && bit_reg == 4'h8) begin
            bit_reg <= 4'h0;
            if (state_reg == ST_WR || sh_reg[7:1] == my_addr_reg) begin
              state_reg <= ST_ACK;
              sda_oe_reg <= 1'b1;
              if (state_reg == ST_ADDR) begin
                rd_reg <= sh_reg[0];
              end
            end else begin
              state_reg <= ST_SKIP;
            end
          end
        end
        ST_ACK: begin
          if (ev.fall) begin
            if (rd_reg) begin
              state_reg <= ST_RD;
              sh_reg <= RD_DATA_I;
              sda_oe_reg <= !RD_DATA_I[7];
              bit_reg <= 4'h1;
            end else begin
              state_reg <= ST_WR;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        ST_RD: begin
          if (ev.fall) begin
            if (bit_reg == 4'h8) begin
              state_reg <= ST_RACK;
              sda_oe_reg <= 1'b0;
            end else begin
              sda_oe_reg <= !sh_reg[3'(7 - bit_reg)];
              bit_reg <= bit_reg + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (ev.rise) begin
            state_reg <= sda ? ST_SKIP : ST_ACK;
          end
        end
        ST_SKIP: state_reg <= ST_SKIP;
        ST_IDLE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Completed write data bytes to the register side
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      xfer_reg <= '0;
      xvalid_reg <= 1'b0;
    end else begin
      xvalid_reg <= 1'b0;
      if (pg_ok && ready_reg && !abort && state_reg == ST_WR &&
          ev.fall && bit_reg == 4'h8) begin
        xfer_reg <= '{data: sh_reg, is_read: 1'b0};
        xvalid_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      to_reg <= 1'b0;
    end else begin
      to_reg <= abort;
    end
  end

  assign SDA_O = 1'b0;
  assign SDA_OE_O = sda_oe_reg;
  assign XFER_O = xfer_reg;
  assign XFER_VALID_O = xvalid_reg;
  assign READY_O = ready_reg && pg_ok;
  assign TIMEOUT_O = to_reg;

  property p_abort_release;
    @(posedge CLK_I) disable iff (RST_I)
    abort |=> !SDA_OE_O && state_reg == ST_IDLE;
  endproperty
  a_abort_release: assert property (p_abort_release)
    else $error("bus not released after timeout");
  property p_scl_timeout;
    @(posedge CLK_I) disable iff (RST_I)
    scl_to |=> TIMEOUT_O;
  endproperty
  a_scl_timeout: assert property (p_scl_timeout)
    else $error("clock timeout not flagged");
  property p_reset_state;
    @(posedge CLK_I) disable iff (RST_I)
    scl_to |=> state_reg == ST_IDLE;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("state not reset after clock timeout");
  property p_supply;
    @(posedge CLK_I) disable iff (RST_I)
    !pg_ok |=> !SDA_OE_O && !XFER_VALID_O;
  endproperty
  a_supply: assert property (p_supply)
    else $error("driving bus without supply good");
  property p_ready;
    @(posedge CLK_I) disable iff (RST_I)
    $rose(ready_reg) |-> por_reg == POR_CYC;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready at wrong time");
  property p_addr;
    @(posedge CLK_I) disable iff (RST_I)
    ready_reg |-> my_addr_reg inside {`ADDR_BASE, `ADDR_MID, `ADDR_HIGH};
  endproperty
  a_addr: assert property (p_addr)
    else $error("bad target address");
  property p_restart;
    @(posedge CLK_I) disable iff (RST_I)
    scl |=> !scl_to && u_scl_timer.cnt_reg == 20'h0_0000;
  endproperty
  a_restart: assert property (p_restart)
    else $error("timeout while line high");
  property p_stable_ready;
    @(posedge CLK_I) disable iff (RST_I)
    ready_reg |=> ready_reg;
  endproperty
  a_stable_ready: assert property (p_stable_ready)
    else $error("ready dropped");
  c_write: cover property (@(posedge CLK_I) XFER_VALID_O);
  c_read: cover property (@(posedge CLK_I) state_reg == ST_RD);
  c_sda_to: cover property (@(posedge CLK_I) sda_to);
  c_scl_to: cover property (@(posedge CLK_I) scl_to);
endmodule
`default_nettype wire

// ===== smbus_host_model.sv
// Bus master model that drives the target port's clock and data
`timescale 1ns/100ps
`default_nettype none
module smbus_host_model #(
  parameter int Q = 50
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // Clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wq(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic start_c();
    sda_o = 1'b1;
    wq(Q);
    scl_o = 1'b1;
    wq(Q);
    sda_o = 1'b0;
    wq(2 * Q);
    scl_o = 1'b0;
  endtask
  task automatic stop_c();
    sda_o = 1'b0;
    wq(Q);
    scl_o = 1'b1;
    wq(Q);
    sda_o = 1'b1;
    wq(22 * Q);
  endtask
  task automatic hold_sda(input int n);
    sda_o = 1'b0;
    wq(n);
  endtask
  // MSB first; read data is sampled while the clock is high
  task automatic xfer(input logic [8:0] b, input int n,
                      output logic [8:0] r);
    for (int i = 8; i > 8 - n; i--) begin
      sda_o = b[i];
      wq(Q);
      scl_o = 1'b1;
      wq(Q);
      r[i] = sda_i;
      wq(Q);
      scl_o = 1'b0;
      wq(Q);
    end
    // Release, then let an edge pass before the next drive
    sda_o = 1'b1;
    wq(1);
  endtask
endmodule
`default_nettype wire

// ===== smbus_target_tb.sv
// Self-checking bench for the serial target port
`timescale 1ns/100ps
`default_nettype none
`include "smbus_tgt_defines.svh"
module smbus_target_tb;
  import smbus_tgt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sg = 1'b1;
  addr_sel_e sel = SEL_LOW;
  logic scl;
  logic host_sda;
  logic sda_o;
  logic sda_oe;
  wire logic sda_line;
  xfer_s xfer;
  xfer_s last_x;
  logic xv;
  logic ready;
  logic timeout;
  logic [8:0] r;
  int error_cnt = 0;
  int total_checks = 0;
  int vcnt = 0;
  int to_cnt = 0;
  localparam logic [6:0] ADDRS [3] = '{`ADDR_BASE, `ADDR_MID, `ADDR_HIGH};
  // Pull-up: a released line reads high
  assign sda_line = sda_oe ? (host_sda & sda_o) : host_sda;
  smbus_target i_smbus_target (
    .CLK_I(clk), .RST_I(rst), .SUPPLY_GOOD_INPUT_I(sg),
    .TARGET_ADDRESS_SELECT_I(sel), .SCL_I(scl), .SDA_I(sda_line),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .XFER_O(xfer), .XFER_VALID_O(xv),
    .RD_DATA_I(8'h3c), .READY_O(ready), .TIMEOUT_O(timeout));
  smbus_host_model i_smbus_host_model (
    .clk_i(clk), .sda_i(sda_line), .scl_o(scl), .sda_o(host_sda));
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (xv === 1'b1) begin
      vcnt++;
      last_x <= xfer;
    end
    if (timeout === 1'b1) begin
      to_cnt++;
    end
  end
  task automatic check(input string n, input logic [8:0] s, e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 100100 && ready !== 1'b1; i++)
      @(negedge clk);
    check("ready", ready, 1'b1);
  endtask
  task automatic do_reset(input addr_sel_e s);
    @(negedge clk);
    rst = 1'b1;
    sel = s;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    wait_ready();
  endtask
  task automatic addr(input logic [6:0] a, input logic rw, ak);
    i_smbus_host_model.start_c();
    i_smbus_host_model.xfer({a, rw, 1'b1}, 9, r);
    check("addr_ack", r[0], ak);
  endtask
  // Timer must not fire early, then pulse once within a short window
  task automatic to_expect(input int t0, input int pre);
    i_smbus_host_model.wq(pre);
    check("early_to", 9'(to_cnt - t0), 9'd0);
    for (int i = 0; i < 2000 && to_cnt == t0; i++)
      @(negedge clk);
    repeat (3) @(negedge clk);
    check("to_pulse", 9'(to_cnt - t0), 9'd1);
    check("released", sda_oe, 1'b0);
    i_smbus_host_model.stop_c();
    addr(ADDRS[2], 1'b0, 1'b0);
    i_smbus_host_model.stop_c();
  endtask
  task automatic t_select();
    for (int k = 0; k < 3; k++) begin
      do_reset(addr_sel_e'(k));
      addr(ADDRS[k], 1'b0, 1'b0);
      i_smbus_host_model.stop_c();
      addr(ADDRS[(k + 1) % 3], 1'b0, 1'b1);
      i_smbus_host_model.stop_c();
    end
  endtask
  task automatic t_rw();
    int v0;
    v0 = vcnt;
    addr(ADDRS[2], 1'b0, 1'b0);
    i_smbus_host_model.xfer(9'h14b, 9, r);
    check("data_ack", r[0], 1'b0);
    i_smbus_host_model.stop_c();
    check("valid_cnt", 9'(vcnt - v0), 9'd1);
    check("xfer", last_x, {8'ha5, 1'b0});
    addr(ADDRS[2], 1'b1, 1'b0);
    i_smbus_host_model.xfer(9'h1ff, 9, r);
    check("rd_data", {1'b0, r[8:1]}, 9'h03c);
    i_smbus_host_model.stop_c();
  endtask
  task automatic t_supply();
    sg = 1'b0;
    repeat (4) @(negedge clk);
    check("ready_off", ready, 1'b0);
    addr(ADDRS[2], 1'b0, 1'b1);
    i_smbus_host_model.stop_c();
    sg = 1'b1;
    wait_ready();
  endtask
  // Clock stalls in the data phase with data released, so only it times out
  task automatic t_scl_to();
    int t0;
    t0 = to_cnt;
    addr(ADDRS[2], 1'b0, 1'b0);
    check("ack_released", sda_oe, 1'b0);
    to_expect(t0, 599000);
  endtask
  task automatic t_sda_to();
    int t0;
    t0 = to_cnt;
    i_smbus_host_model.hold_sda(599000);
    to_expect(t0, 0);
  endtask
  // Two long lows split by one clock pulse must not time out
  task automatic t_restart();
    int t0;
    t0 = to_cnt;
    addr(ADDRS[2], 1'b0, 1'b0);
    i_smbus_host_model.wq(310000);
    i_smbus_host_model.xfer(9'h100, 1, r);
    i_smbus_host_model.wq(310000);
    check("no_to", 9'(to_cnt - t0), 9'd0);
    i_smbus_host_model.stop_c();
  endtask
  initial begin
    t_select();
    t_rw();
    t_supply();
    t_scl_to();
    t_sda_to();
    t_restart();
    give_verdict();
  end
  // Whole run is near 2.2 million cycles, set by the 30 ms timeouts
  initial begin
    repeat (3000000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire
